// *** rtl/ssr_core.sv ***
// synchronous serial receiver: wishbone registers, clock master/slave and two-character fifo
//
// The placing of the registers and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
module ssr_core
   import ssr_pkg::*;
(
   // clock and reset
   input wire logic CORE_CLK_I,
   input wire logic RST_I,
   // wishbone slave
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [4:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   // serial data pin
   input wire logic RX_DATA_I,
   output logic RX_DATA_O,
   output logic RX_DATA_OE_O,
   // serial clock pin
   input wire logic CLK_PIN_I,
   output logic CLK_PIN_O,
   output logic CLK_PIN_OE_O,
   // interrupt request
   output logic IRQ_O
);

   // software-visible control
   logic serial_port_enable_reg, nine_reg, single_reg, cont_reg;
   logic master_reg, sync_reg, wide_reg, high_rate_reg, irq_en_reg;
   logic [7:0] div_lo_reg, div_hi_reg;
   // status
   logic overrun_reg, ovr_single_reg;
   // fifo
   logic [8:0] fifo_mem [0:1];
   logic rd_ptr_reg, wr_ptr_reg;
   logic [1:0] fifo_cnt_reg;
   // sequencer
   ssr_state_t state_reg;
   logic [17:0] half_cnt_reg;
   logic [3:0] bit_cnt_reg;
   logic [8:0] shift_reg;
   logic sclk_reg;
   // pin synchronisers
   logic rx_meta_reg, rx_sync_reg, ck_meta_reg, ck_sync_reg, ck_prev_reg;
   // bus
   logic ack_reg, irq_reg, clk_oe_reg, rx_oe_reg;
   logic [31:0] dat_reg;

   // bus decode, effects happen on the edge that samples ack high
   logic bus_req, bus_wr, bus_rd_data, wr_lane;
   assign bus_req = WB_CYC_I & WB_STB_I;
   assign bus_wr = bus_req & ack_reg & WB_WE_I;
   assign wr_lane = WB_SEL_I[0];
   assign bus_rd_data = bus_req & ack_reg & ~WB_WE_I & (WB_ADR_I == SSR_OFS_DATA);

   // sequencer controls
   logic rx_enable, slave_fall, master_term, take_bit, char_done, push, pop;
   logic [17:0] half_len;
   logic [15:0] divisor;
   logic [3:0] char_bits;
   logic [8:0] char_word;
   assign divisor = wide_reg ? {div_hi_reg, div_lo_reg} : {8'h00, div_lo_reg};
   assign half_len = 18'(SSR_HALF_MULT) * (18'(divisor) + 18'h00001);
   assign char_bits = nine_reg ? SSR_BITS_9 : SSR_BITS_8;
   assign rx_enable = serial_port_enable_reg & sync_reg & (single_reg | cont_reg) & ~overrun_reg;
   assign slave_fall = ck_prev_reg & ~ck_sync_reg;
   assign master_term = (half_cnt_reg == half_len - 18'h00001);
   // trailing edge: own falling edge as master, pin falling edge as slave
   assign take_bit = rx_enable & (master_reg ? (state_reg == SSR_ST_HIGH) & master_term
                                             : (state_reg == SSR_ST_LOW) & slave_fall);
   assign char_done = take_bit & (bit_cnt_reg == char_bits - 4'h1);
   // assembled word with the last bit included
   always_comb begin
      char_word = shift_reg;
      char_word[bit_cnt_reg] = rx_sync_reg;
      if (!nine_reg) begin
         char_word[8] = 1'b0;
      end
   end
   assign push = char_done & (fifo_cnt_reg != SSR_FIFO_DEPTH);
   assign pop = bus_rd_data & (fifo_cnt_reg != 2'h0);

   // pin synchronisers, first stage feeds only the second
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         rx_meta_reg <= 1'b0;
         rx_sync_reg <= 1'b0;
         ck_meta_reg <= 1'b0;
         ck_sync_reg <= 1'b0;
         ck_prev_reg <= 1'b0;
      end else begin
         rx_meta_reg <= RX_DATA_I;
         rx_sync_reg <= rx_meta_reg;
         ck_meta_reg <= CLK_PIN_I;
         ck_sync_reg <= ck_meta_reg;
         ck_prev_reg <= ck_sync_reg;
      end
   end

   // receive control register, hardware clears single receive after a character
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         serial_port_enable_reg <= SSR_RST_RX_CTRL[SSR_BIT_SERIAL_PORT_ENABLE];
         nine_reg <= SSR_RST_RX_CTRL[SSR_BIT_NINE];
         single_reg <= SSR_RST_RX_CTRL[SSR_BIT_SINGLE];
         cont_reg <= SSR_RST_RX_CTRL[SSR_BIT_CONT];
      end else if (bus_wr && wr_lane && WB_ADR_I == SSR_OFS_RX_CTRL) begin
         serial_port_enable_reg <= WB_DAT_I[SSR_BIT_SERIAL_PORT_ENABLE];
         nine_reg <= WB_DAT_I[SSR_BIT_NINE];
         single_reg <= WB_DAT_I[SSR_BIT_SINGLE];
         cont_reg <= WB_DAT_I[SSR_BIT_CONT];
      end else if (char_done) begin
         single_reg <= 1'b0;
      end
   end

   // mode, divisor and irq enable registers
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         master_reg <= SSR_RST_MODE[SSR_BIT_MASTER];
         sync_reg <= SSR_RST_MODE[SSR_BIT_SYNC];
         wide_reg <= SSR_RST_MODE[SSR_BIT_WIDE];
         high_rate_reg <= SSR_RST_MODE[SSR_BIT_HIGH_RATE];
         div_lo_reg <= SSR_RST_DIV;
         div_hi_reg <= SSR_RST_DIV;
         irq_en_reg <= SSR_RST_IRQ_EN;
      end else if (bus_wr && wr_lane) begin
         case (WB_ADR_I)
            SSR_OFS_MODE: begin
               master_reg <= WB_DAT_I[SSR_BIT_MASTER];
               sync_reg <= WB_DAT_I[SSR_BIT_SYNC];
               wide_reg <= WB_DAT_I[SSR_BIT_WIDE];
               high_rate_reg <= WB_DAT_I[SSR_BIT_HIGH_RATE]; // no effect in sync mode
            end
            SSR_OFS_DIV_LO: div_lo_reg <= WB_DAT_I[7:0];
            SSR_OFS_DIV_HI: div_hi_reg <= WB_DAT_I[7:0];
            SSR_OFS_IRQ: irq_en_reg <= WB_DAT_I[SSR_BIT_IRQ_EN];
            default: irq_en_reg <= irq_en_reg;
         endcase
      end
   end

   // overrun flag, a new overrun wins over a clearing read in the same cycle
   logic cont_clear;
   assign cont_clear = ~cont_reg | ~serial_port_enable_reg;
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         overrun_reg <= 1'b0;
         ovr_single_reg <= 1'b0;
      end else if (char_done && !push) begin
         overrun_reg <= 1'b1;
         ovr_single_reg <= single_reg & ~cont_reg;
      end else if (!serial_port_enable_reg) begin
         overrun_reg <= 1'b0;
      end else if (overrun_reg && (ovr_single_reg ? bus_rd_data : cont_clear)) begin
         overrun_reg <= 1'b0;
      end
   end

   // two-character fifo, emptied when the port is disabled
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         rd_ptr_reg <= 1'b0;
         wr_ptr_reg <= 1'b0;
         fifo_cnt_reg <= 2'h0;
      end else if (!serial_port_enable_reg) begin
         rd_ptr_reg <= 1'b0;
         wr_ptr_reg <= 1'b0;
         fifo_cnt_reg <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr_reg <= ~wr_ptr_reg;
         end
         if (pop) begin
            rd_ptr_reg <= ~rd_ptr_reg;
         end
         fifo_cnt_reg <= fifo_cnt_reg + {1'b0, push} - {1'b0, pop};
      end
   end

   // fifo storage has no reset
   always_ff @(posedge CORE_CLK_I) begin
      if (push) begin
         fifo_mem[wr_ptr_reg] <= char_word;
      end
   end

   // receive sequencer and master clock generator
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         state_reg <= SSR_ST_IDLE;
         half_cnt_reg <= 18'h00000;
         bit_cnt_reg <= 4'h0;
         shift_reg <= 9'h000;
         sclk_reg <= 1'b0;
      end else if (!rx_enable) begin
         // stop at once and drop any partial character
         state_reg <= SSR_ST_IDLE;
         half_cnt_reg <= 18'h00000;
         bit_cnt_reg <= 4'h0;
         sclk_reg <= 1'b0;
      end else begin
         case (state_reg)
            SSR_ST_IDLE: begin
               state_reg <= SSR_ST_LOW;
               half_cnt_reg <= 18'h00000;
               bit_cnt_reg <= 4'h0;
               shift_reg <= 9'h000;
               sclk_reg <= 1'b0;
            end
            SSR_ST_LOW: begin
               if (master_reg) begin
                  if (master_term) begin
                     state_reg <= SSR_ST_HIGH;
                     half_cnt_reg <= 18'h00000;
                     sclk_reg <= 1'b1; // leading edge
                  end else begin
                     half_cnt_reg <= half_cnt_reg + 18'h00001;
                  end
               end else if (take_bit) begin
                  shift_reg[bit_cnt_reg] <= rx_sync_reg;
                  bit_cnt_reg <= char_done ? 4'h0 : bit_cnt_reg + 4'h1;
               end
            end
            SSR_ST_HIGH: begin
               if (master_term) begin
                  sclk_reg <= 1'b0; // trailing edge
                  half_cnt_reg <= 18'h00000;
                  shift_reg[bit_cnt_reg] <= rx_sync_reg;
                  bit_cnt_reg <= char_done ? 4'h0 : bit_cnt_reg + 4'h1;
                  state_reg <= char_done ? SSR_ST_IDLE : SSR_ST_LOW;
               end else begin
                  half_cnt_reg <= half_cnt_reg + 18'h00001;
               end
            end
            default: state_reg <= SSR_ST_IDLE;
         endcase
      end
   end

   // pin drivers: data pin never driven, clock pin driven only as sync master
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         rx_oe_reg <= 1'b0;
         clk_oe_reg <= 1'b0;
      end else begin
         rx_oe_reg <= 1'b0;
         clk_oe_reg <= serial_port_enable_reg & sync_reg & master_reg;
      end
   end

   // interrupt while characters are waiting and enabled
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= irq_en_reg & (fifo_cnt_reg != 2'h0);
      end
   end

   // read mux
   logic [8:0] head;
   logic [31:0] rd_value;
   assign head = fifo_mem[rd_ptr_reg];
   always_comb begin
      rd_value = 32'h00000000;
      case (WB_ADR_I)
         SSR_OFS_RX_CTRL: begin
            rd_value[SSR_BIT_SERIAL_PORT_ENABLE] = serial_port_enable_reg;
            rd_value[SSR_BIT_NINE] = nine_reg;
            rd_value[SSR_BIT_SINGLE] = single_reg;
            rd_value[SSR_BIT_CONT] = cont_reg;
            rd_value[SSR_BIT_OVERRUN] = overrun_reg;
            rd_value[SSR_BIT_NINTH] = (fifo_cnt_reg != 2'h0) & head[8];
         end
         SSR_OFS_MODE: begin
            rd_value[SSR_BIT_MASTER] = master_reg;
            rd_value[SSR_BIT_SYNC] = sync_reg;
            rd_value[SSR_BIT_WIDE] = wide_reg;
            rd_value[SSR_BIT_HIGH_RATE] = high_rate_reg;
         end
         SSR_OFS_DATA: rd_value[7:0] = (fifo_cnt_reg != 2'h0) ? head[7:0] : 8'h00;
         SSR_OFS_DIV_LO: rd_value[7:0] = div_lo_reg;
         SSR_OFS_DIV_HI: rd_value[7:0] = div_hi_reg;
         SSR_OFS_IRQ: begin
            rd_value[SSR_BIT_IRQ_EN] = irq_en_reg;
            rd_value[SSR_BIT_DONE] = (fifo_cnt_reg != 2'h0);
         end
         default: rd_value = 32'h00000000;
      endcase
   end

   // wishbone answer: ack one cycle after the request, dropped the next cycle
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h00000000;
      end else begin
         ack_reg <= bus_req & ~ack_reg;
         if (bus_req && !ack_reg) begin
            dat_reg <= rd_value;
         end
      end
   end

   assign WB_ACK_O = ack_reg;
   assign WB_DAT_O = dat_reg;
   assign RX_DATA_O = rx_oe_reg;
   assign RX_DATA_OE_O = rx_oe_reg;
   assign CLK_PIN_O = sclk_reg;
   assign CLK_PIN_OE_O = clk_oe_reg;
   assign IRQ_O = irq_reg;

endmodule // ssr_core

// *** shared/ssr_pkg.sv ***
// constants and types shared by the synchronous serial receiver
package ssr_pkg;
   // register byte offsets on the wishbone bus
   localparam logic [4:0] SSR_OFS_RX_CTRL = 5'h00; // receive_status_control
   localparam logic [4:0] SSR_OFS_MODE = 5'h04; // master / sync / rate selects
   localparam logic [4:0] SSR_OFS_DATA = 5'h08; // receive_data_reg
   localparam logic [4:0] SSR_OFS_DIV_LO = 5'h0c; // divisor_low
   localparam logic [4:0] SSR_OFS_DIV_HI = 5'h10; // divisor_high
   localparam logic [4:0] SSR_OFS_IRQ = 5'h14; // irq enable and done flag
   // receive_status_control bit positions
   localparam int SSR_BIT_SERIAL_PORT_ENABLE = 7;
   localparam int SSR_BIT_NINE = 6;
   localparam int SSR_BIT_SINGLE = 5;
   localparam int SSR_BIT_CONT = 4;
   localparam int SSR_BIT_OVERRUN = 1;
   localparam int SSR_BIT_NINTH = 0;
   // mode register bit positions
   localparam int SSR_BIT_MASTER = 7;
   localparam int SSR_BIT_SYNC = 4;
   localparam int SSR_BIT_WIDE = 3;
   localparam int SSR_BIT_HIGH_RATE = 2;
   // irq register bit positions
   localparam int SSR_BIT_IRQ_EN = 0;
   localparam int SSR_BIT_DONE = 1;
   // values after reset
   localparam logic [7:0] SSR_RST_RX_CTRL = 8'h00;
   localparam logic [7:0] SSR_RST_MODE = 8'h00;
   localparam logic [7:0] SSR_RST_DIV = 8'h00;
   localparam logic SSR_RST_IRQ_EN = 1'b0;
   // fifo depth and character sizes
   localparam logic [1:0] SSR_FIFO_DEPTH = 2'h2;
   localparam logic [3:0] SSR_BITS_8 = 4'h8;
   localparam logic [3:0] SSR_BITS_9 = 4'h9;
   // serial clock is (divisor+1)*4 cycles per period, so half a period is 2*(n+1)
   localparam int SSR_HALF_MULT = 2;
   // receive sequencer states, gray along idle -> low -> high
   typedef enum logic [1:0] {
      SSR_ST_IDLE = 2'b00,
      SSR_ST_LOW = 2'b01,
      SSR_ST_HIGH = 2'b11
   } ssr_state_t;
endpackage

// *** testbench/ssr_core_assertions.sv ***
// concurrent checks on the synchronous serial receiver ports
`timescale 1ns/1ps
module ssr_core_checker (
   // clock and reset
   input wire logic CORE_CLK_I,
   input wire logic RST_I,
   // wishbone
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic WB_ACK_O,
   // pins and interrupt
   input wire logic RX_DATA_OE_O,
   input wire logic CLK_PIN_O,
   input wire logic CLK_PIN_OE_O,
   input wire logic IRQ_O
);
   // all checks run on the system clock, quiet in reset
   default clocking cb @(posedge CORE_CLK_I);
   endclocking
   default disable iff (RST_I);
   data_oe_off_a: assert property (!RX_DATA_OE_O) else $error("data pin driver on");
   ack_next_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("no ack");
   ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
   dat_upper_a: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0) else $error("upper read bits set");
   clk_high_a: assert property ($fell(CLK_PIN_O) && !WB_ACK_O && !$past(WB_ACK_O) && !$past(WB_ACK_O, 2)
      |-> $past(CLK_PIN_O, 4) && !$past(CLK_PIN_O, 5)) else $error("clock high half wrong");
   clk_low_a: assert property ($rose(CLK_PIN_O) |-> !$past(CLK_PIN_O, 2) && !$past(CLK_PIN_O, 4))
      else $error("clock low half too short");
   oe_change_a: assert property ($changed(CLK_PIN_OE_O) |-> $past(WB_ACK_O, 2) && $past(WB_WE_I, 2))
      else $error("clock driver changed without write");
   irq_fall_a: assert property ($fell(IRQ_O) |-> $past(WB_ACK_O) || $past(WB_ACK_O, 2) || $past(WB_ACK_O, 3))
      else $error("irq dropped without access");
   // main scenarios
   cover property ($rose(IRQ_O));
   cover property ($rose(CLK_PIN_O));
   cover property (WB_ACK_O && !WB_WE_I);
endmodule // ssr_core_checker
bind ssr_core ssr_core_checker i_ssr_core_checker (.CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .WB_CYC_I(WB_CYC_I),
   .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
   .RX_DATA_OE_O(RX_DATA_OE_O), .CLK_PIN_O(CLK_PIN_O), .CLK_PIN_OE_O(CLK_PIN_OE_O), .IRQ_O(IRQ_O));

// *** testbench/ssr_core_bench.sv ***
// testbench for the synchronous serial receiver
`timescale 1ns/1ps
module ssr_core_bench
   import ssr_pkg::*;
;
   logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, we = 1'b0, load = 1'b1, cpin = 1'b0, prev = 1'b0;
   logic ack, rxd, cko, coe, doe, irq, rdo;
   logic [4:0] adr = 5'h00;
   logic [31:0] dat = 32'h0, dout, q, base, rises = 32'h0, cycles = 32'h0;
   logic [35:0] stream = 36'h0;
   logic [4:0] tab [6] = '{SSR_OFS_RX_CTRL, SSR_OFS_MODE, SSR_OFS_DATA, SSR_OFS_DIV_LO, SSR_OFS_IRQ, 5'h18};
   int error_cnt = 0;
   int n_tests = 0;
   // clock generator
   always #5 clk = ~clk;
   ssr_core i_ssr_core (.CORE_CLK_I(clk), .RST_I(rst), .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(dat), .WB_DAT_O(dout), .WB_ACK_O(ack), .RX_DATA_I(rxd),
      .RX_DATA_O(rdo), .RX_DATA_OE_O(doe), .CLK_PIN_I(cpin), .CLK_PIN_O(cko), .CLK_PIN_OE_O(coe), .IRQ_O(irq));
   // the peer follows whichever side owns the serial clock: the block as master, the bench as master
   ssr_peer i_ssr_peer (.clk_i(clk), .load_i(load), .stream_i(stream), .line_i(cko | cpin), .data_o(rxd));
   // counts generated clock rises and cuts a hang short
   always @(posedge clk) begin
      prev <= cko;
      cycles <= cycles + 1;
      if (cko && !prev) begin
         rises <= rises + 1;
      end
      if (cycles == 32'd20000) begin
         error_cnt++;
         test_done();
      end
   end
   task automatic test_done();
      if (error_cnt == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one classic wishbone cycle, held until ack
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do @(posedge clk); while (ack !== 1'b1);
      q = dout;
      cyc <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd_chk(input string nm, input logic [4:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(nm, e, q);
   endtask
   // loads the peer and starts reception with a control value
   task automatic go(input logic [35:0] s, input logic [7:0] c);
      base = rises;
      stream <= s;
      load <= 1'b1;
      @(posedge clk);
      load <= 1'b0;
      bus(1'b1, SSR_OFS_RX_CTRL, {24'h0, c});
   endtask
   task automatic poll(input logic [7:0] m, input logic [7:0] v);
      do bus(1'b0, SSR_OFS_RX_CTRL, 32'h0); while ((q[7:0] & m) !== v);
   endtask
   task automatic single(input logic [7:0] c);
      poll(8'h20, 8'h00);
      chk("rises", 32'd8, rises - base);
      chk("irq", 1'b1, irq);
      rd_chk("done", SSR_OFS_IRQ, 32'h3);
      rd_chk("data", SSR_OFS_DATA, {24'h0, c});
      rd_chk("done", SSR_OFS_IRQ, 32'h1);
   endtask
   // main sequence
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      load <= 1'b0;
      foreach (tab[i]) rd_chk("reset", tab[i], 32'h0);
      bus(1'b1, SSR_OFS_DIV_LO, 32'h1);
      bus(1'b1, SSR_OFS_DIV_HI, 32'h1); // unused without wide select
      bus(1'b1, SSR_OFS_MODE, 32'h90);
      bus(1'b1, SSR_OFS_IRQ, 32'h1);
      bus(1'b1, SSR_OFS_RX_CTRL, 32'h80);
      chk("data_oe", 1'b0, doe);
      chk("data_out", 1'b0, rdo);
      go(36'ha5, 8'ha0);
      chk("clk_oe", 1'b1, coe);
      single(8'ha5);
      // continuous reception aborted after three bits
      go(36'hff, 8'h90);
      while (rises - base < 3) @(posedge clk);
      bus(1'b1, SSR_OFS_RX_CTRL, 32'h80);
      repeat (20) @(posedge clk);
      chk("rises", 32'd3, rises - base);
      chk("clk", 1'b0, cko);
      rd_chk("done", SSR_OFS_IRQ, 32'h1);
      go(36'h3c, 8'ha0);
      single(8'h3c);
      // nine-bit, both enables, third character overruns
      go({9'h0, 9'h1ff, 9'h05a, 9'h1c3}, 8'hf0);
      poll(8'h02, 8'h02);
      rd_chk("ctrl", SSR_OFS_RX_CTRL, 32'hd3);
      chk("rises", 32'd27, rises - base);
      rd_chk("data", SSR_OFS_DATA, 32'hc3);
      rd_chk("ctrl", SSR_OFS_RX_CTRL, 32'hd2);
      rd_chk("data", SSR_OFS_DATA, 32'h5a);
      rd_chk("data", SSR_OFS_DATA, 32'h0);
      chk("rises", 32'd27, rises - base);
      bus(1'b1, SSR_OFS_RX_CTRL, 32'hc0);
      rd_chk("ctrl", SSR_OFS_RX_CTRL, 32'hc0);
      // single-mode overrun, cleared by a data read
      bus(1'b1, SSR_OFS_RX_CTRL, 32'h80);
      go(36'h11, 8'ha0);
      poll(8'h20, 8'h00);
      go(36'h22, 8'ha0);
      poll(8'h20, 8'h00);
      go(36'h33, 8'ha0);
      poll(8'h02, 8'h02);
      rd_chk("data", SSR_OFS_DATA, 32'h11);
      bus(1'b0, SSR_OFS_RX_CTRL, 32'h0);
      chk("overrun", 32'h0, q & 32'h2);
      rd_chk("data", SSR_OFS_DATA, 32'h22);
      rd_chk("data", SSR_OFS_DATA, 32'h0);
      // port disable empties the fifo, slave mode frees the clock pin
      go(36'h77, 8'ha0);
      poll(8'h20, 8'h00);
      bus(1'b1, SSR_OFS_RX_CTRL, 32'h0);
      rd_chk("done", SSR_OFS_IRQ, 32'h1);
      bus(1'b1, SSR_OFS_MODE, 32'h10);
      chk("clk_oe", 1'b0, coe);
      // slave receive: the bench supplies exactly one character of clocks, four cycles per half
      go(36'h96, 8'ha0);
      chk("clk_oe", 1'b0, coe);
      repeat (8) begin
         cpin <= 1'b1;
         repeat (4) @(posedge clk);
         cpin <= 1'b0;
         repeat (4) @(posedge clk);
      end
      rd_chk("ctrl", SSR_OFS_RX_CTRL, 32'h80);
      rd_chk("data", SSR_OFS_DATA, 32'h96);
      test_done();
   end
endmodule // ssr_core_bench

// *** testbench/ssr_peer.sv ***
// serial peer that answers the generated clock with a bit stream
`timescale 1ns/1ps
module ssr_peer (
   // system clock and stream restart
   input wire logic clk_i,
   input wire logic load_i,
   // bits to send, lsb first, and the serial clock line
   input wire logic [35:0] stream_i,
   input wire logic line_i,
   // serial data line
   output logic data_o
);
   logic line_reg;
   logic [5:0] pos_reg;
   // new bit on the leading edge; while clock is low the line wanders so nothing stale is sampled
   always_ff @(posedge clk_i) begin
      line_reg <= line_i;
      if (load_i) begin
         pos_reg <= 6'h00;
         data_o <= 1'b0;
      end else if (line_i && !line_reg) begin
         data_o <= stream_i[pos_reg];
         pos_reg <= pos_reg + 6'h01;
      end else if (!line_i) begin
         data_o <= ~data_o;
      end
   end
endmodule // ssr_peer
